// ### logic/step_status_top.sv
// table step status outputs and push motion sequencer
`timescale 1ns/1ps
module step_status_top #(
   parameter int unsigned MS_CYCLES = step_status_pkg::MS_CYCLES_DEFAULT  // clocks per ms
) (
   input  wire logic        SYS_CLK_I,      // 40 MHz clock
   input  wire logic        SRST_I,         // synchronous reset, high
   input  wire logic [7:0]  ADDR_I,         // register byte address
   input  wire logic [31:0] WDATA_I,        // write data
   input  wire logic        WR_I,           // write strobe
   input  wire logic        RD_I,           // read strobe
   output logic      [31:0] RDATA_O,        // read data, cycle after RD_I
   input  wire logic        STEP_START_I,   // step motion begins, pulse
   input  wire logic        STEP_DONE_I,    // step motion complete, pulse
   input  wire logic [31:0] POS_I,          // axis position, signed pulses
   input  wire logic        CONTACT_I,      // workpiece detected
   input  wire logic        STOP_CMD_I,     // stop command, pulse
   output logic      [2:0]  STATUS_LINES_O, // step_status_line2..0
   output logic             PUSH_ACTIVE_O,  // force control applied
   output logic             MOTOR_HALT_O,   // stop mode hold after contact
   output logic      [6:0]  FORCE_RATIO_O,  // push force ratio, percent
   output logic      [31:0] PUSH_SPEED_O,   // push speed, pps
   output logic      [31:0] NONSTOP_CNT_O,  // non-stop pulse count
   output logic             IRQ_O           // level interrupt
);
   import step_status_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] mag(input logic [31:0] v);
      return v[31] ? (~v + 32'h0000_0001) : v;
   endfunction

   function automatic logic sel_off(input logic [4:0] s);
      return s[2:0] == 3'b000 || s > 5'h17;
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [31:0]          step_cfg, wait_time, trig_pos, trig_time;
   logic [31:0]          push_ratio, push_speed, push_pos, push_cnt;
   logic [IRQ_W-1:0]     irq_stat, irq_mask;
   logic [31:0]          rdata;
   logic [31:0]          next_step_cfg, next_wait_time, next_trig_pos, next_trig_time;
   logic [31:0]          next_push_ratio, next_push_speed, next_push_pos, next_push_cnt;
   logic [IRQ_W-1:0]     next_irq_stat, next_irq_mask;
   logic [31:0]          next_rdata;
   logic [IRQ_W-1:0]     events;

   logic [4:0] sel;
   assign sel = step_cfg[CFG_SEL_LSB +: CFG_SEL_W];

   // ----------------------------------------------------------------
   // step status sequencing
   // ----------------------------------------------------------------
   pulse_if pif ();

   logic        running, pass_armed;
   logic [4:0]  cur_sel;
   logic [31:0] start_pos;
   logic        next_running, next_pass_armed;
   logic [4:0]  next_cur_sel;
   logic [31:0] next_start_pos;
   logic [31:0] travel;
   logic        pass_hit, end_suppress;

   assign travel       = POS_I - start_pos;
   assign pass_hit     = pass_armed && mag(travel) >= mag(trig_pos);
   // jump with zero wait drops end code
   assign end_suppress = step_cfg[CFG_JUMP_BIT] && wait_time[WAIT_W-1:0] == '0;

   always_comb begin
      next_running    = running;
      next_pass_armed = pass_armed;
      next_cur_sel    = cur_sel;
      next_start_pos  = start_pos;
      pif.fire        = 1'b0;
      pif.code        = sel[2:0];
      pif.width       = trig_time[MS_CNT_W-1:0];
      if (STEP_START_I) begin
         next_running    = 1'b1;
         next_cur_sel    = sel;
         next_start_pos  = POS_I;
         next_pass_armed = !sel_off(sel) && sel >= SEL_PASS_BASE;
         pif.fire        = !sel_off(sel) && sel < SEL_END_BASE;
         pif.code        = sel[2:0];
      end else if (STEP_DONE_I && running) begin
         next_running    = 1'b0;
         next_pass_armed = 1'b0;
         pif.fire        = !sel_off(cur_sel) && cur_sel >= SEL_END_BASE
                           && cur_sel < SEL_PASS_BASE && !end_suppress;
         pif.code        = cur_sel[2:0];
      end else if (pass_hit) begin
         next_pass_armed = 1'b0;
         pif.fire        = 1'b1;
         pif.code        = cur_sel[2:0];
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         running    <= 1'b0;
         pass_armed <= 1'b0;
         cur_sel    <= 5'h00;
         start_pos  <= 32'h0000_0000;
      end else begin
         running    <= next_running;
         pass_armed <= next_pass_armed;
         cur_sel    <= next_cur_sel;
         start_pos  <= next_start_pos;
      end
   end

   // pulse timing lives apart so the long ms prescaler is not in this file
   status_pulse_gen #(.MS_CYCLES(MS_CYCLES)) u_pulse (
      .clk_i  (SYS_CLK_I),
      .srst_i (SRST_I),
      .pif    (pif.gen)
   );

   assign STATUS_LINES_O = pif.lines;

   // ----------------------------------------------------------------
   // push motion
   // ----------------------------------------------------------------
   push_state_type push_state, next_push_state;

   always_comb begin
      next_push_state = push_state;
      case (push_state)
         PUSH_IDLE: begin
            if (STEP_START_I && step_cfg[CFG_PUSH_BIT]) begin
               next_push_state = PUSH_POSN;
            end
         end
         PUSH_POSN: begin
            if (mag(POS_I - start_pos) >= mag(push_pos - start_pos)) begin
               next_push_state = PUSH_FORCE;
            end
         end
         PUSH_FORCE: begin
            if (CONTACT_I) begin
               next_push_state = step_cfg[CFG_NONSTOP_BIT] ? PUSH_NONSTOP : PUSH_HOLD;
            end
         end
         PUSH_HOLD, PUSH_NONSTOP: begin
            if (STOP_CMD_I) begin
               next_push_state = PUSH_IDLE;
            end else if (STEP_START_I) begin
               next_push_state = step_cfg[CFG_PUSH_BIT] ? PUSH_POSN : PUSH_IDLE;
            end
         end
         default: next_push_state = PUSH_IDLE;
      endcase
      if (STOP_CMD_I) begin
         next_push_state = PUSH_IDLE;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         push_state <= PUSH_IDLE;
      end else begin
         push_state <= next_push_state;
      end
   end

   assign PUSH_ACTIVE_O = push_state == PUSH_FORCE || push_state == PUSH_HOLD
                          || push_state == PUSH_NONSTOP;
   assign MOTOR_HALT_O  = push_state == PUSH_HOLD;
   assign FORCE_RATIO_O = push_ratio[RATIO_W-1:0];
   assign PUSH_SPEED_O  = push_speed;
   assign NONSTOP_CNT_O = push_cnt;

   // ----------------------------------------------------------------
   // register bus and interrupts
   // ----------------------------------------------------------------
   assign events[IRQ_PULSE_BIT]   = pif.fire;
   assign events[IRQ_DONE_BIT]    = STEP_DONE_I && running;
   assign events[IRQ_CONTACT_BIT] = push_state == PUSH_FORCE && CONTACT_I;

   always_comb begin
      next_step_cfg   = step_cfg;
      next_wait_time  = wait_time;
      next_trig_pos   = trig_pos;
      next_trig_time  = trig_time;
      next_push_ratio = push_ratio;
      next_push_speed = push_speed;
      next_push_pos   = push_pos;
      next_push_cnt   = push_cnt;
      next_irq_mask   = irq_mask;
      next_rdata      = 32'h0000_0000;
      next_irq_stat   = irq_stat;
      if (WR_I) begin
         case (ADDR_I)
            STEP_CFG_OFS:   next_step_cfg   = {21'h0_0000, WDATA_I[10:8], 3'h0, WDATA_I[4:0]};
            WAIT_TIME_OFS:  next_wait_time  = {16'h0000, WDATA_I[15:0]};
            TRIG_POS_OFS:   next_trig_pos   = WDATA_I;
            TRIG_TIME_OFS:  next_trig_time  = {16'h0000, WDATA_I[15:0]};
            PUSH_RATIO_OFS: next_push_ratio = {25'h000_0000, WDATA_I[6:0]};
            PUSH_SPEED_OFS: next_push_speed = WDATA_I;
            PUSH_POS_OFS:   next_push_pos   = WDATA_I;
            PUSH_CNT_OFS:   next_push_cnt   = WDATA_I;
            IRQ_MASK_OFS:   next_irq_mask   = WDATA_I[IRQ_W-1:0];
            default:        next_rdata      = 32'h0000_0000;
         endcase
      end
      if (RD_I) begin
         case (ADDR_I)
            STEP_CFG_OFS:   next_rdata = step_cfg;
            WAIT_TIME_OFS:  next_rdata = wait_time;
            TRIG_POS_OFS:   next_rdata = trig_pos;
            TRIG_TIME_OFS:  next_rdata = trig_time;
            PUSH_RATIO_OFS: next_rdata = push_ratio;
            PUSH_SPEED_OFS: next_rdata = push_speed;
            PUSH_POS_OFS:   next_rdata = push_pos;
            PUSH_CNT_OFS:   next_rdata = push_cnt;
            IRQ_STAT_OFS: begin
               next_rdata    = {29'h0000_0000, irq_stat};
               next_irq_stat = '0;
            end
            IRQ_MASK_OFS:   next_rdata = {29'h0000_0000, irq_mask};
            STATE_OFS:      next_rdata = {24'h00_0000, running, push_state, pif.busy, pif.lines};
            default:        next_rdata = 32'h0000_0000;
         endcase
      end
      // events win over a clearing read
      next_irq_stat = next_irq_stat | events;
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         step_cfg   <= REG_RESET;
         wait_time  <= REG_RESET;
         trig_pos   <= REG_RESET;
         trig_time  <= REG_RESET;
         push_ratio <= REG_RESET;
         push_speed <= REG_RESET;
         push_pos   <= REG_RESET;
         push_cnt   <= REG_RESET;
         irq_stat   <= '0;
         irq_mask   <= '0;
         rdata      <= REG_RESET;
      end else begin
         step_cfg   <= next_step_cfg;
         wait_time  <= next_wait_time;
         trig_pos   <= next_trig_pos;
         trig_time  <= next_trig_time;
         push_ratio <= next_push_ratio;
         push_speed <= next_push_speed;
         push_pos   <= next_push_pos;
         push_cnt   <= next_push_cnt;
         irq_stat   <= next_irq_stat;
         irq_mask   <= next_irq_mask;
         rdata      <= next_rdata;
      end
   end

   assign RDATA_O = rdata;
   assign IRQ_O   = |(irq_stat & irq_mask);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (SRST_I);

   property p_off_silent;
      (STEP_START_I && sel_off(sel)) || (!STEP_START_I && STEP_DONE_I && running && sel_off(cur_sel))
         |-> !pif.fire;
   endproperty
   a_off_silent: assert property (p_off_silent) else $error("status fired for unused select");

   property p_start_fire;
      STEP_START_I && sel >= 5'h01 && sel <= 5'h07 |-> pif.fire && pif.code == sel[2:0];
   endproperty
   a_start_fire: assert property (p_start_fire) else $error("start code missing");

   property p_end_fire;
      !STEP_START_I && STEP_DONE_I && running && cur_sel >= 5'h09 && cur_sel <= 5'h0F && !end_suppress
         |-> pif.fire && pif.code == cur_sel[2:0];
   endproperty
   a_end_fire: assert property (p_end_fire) else $error("end code missing");

   property p_pass_pos;
      pif.fire && !STEP_START_I && !STEP_DONE_I |-> cur_sel >= 5'h11 && mag(travel) >= mag(trig_pos);
   endproperty
   a_pass_pos: assert property (p_pass_pos) else $error("pass code at wrong point");

   property p_rel_start;
      STEP_START_I |=> start_pos == $past(POS_I);
   endproperty
   a_rel_start: assert property (p_rel_start) else $error("travel origin not captured");

   property p_suppress;
      STEP_DONE_I && running && !STEP_START_I && end_suppress && cur_sel >= 5'h09
         && cur_sel <= 5'h0F |-> !pif.fire;
   endproperty
   a_suppress: assert property (p_suppress) else $error("end code not suppressed");

   property p_push_contact;
      push_state == PUSH_FORCE && CONTACT_I && !STOP_CMD_I
         |=> push_state == ($past(step_cfg[CFG_NONSTOP_BIT]) ? PUSH_NONSTOP : PUSH_HOLD);
   endproperty
   a_push_contact: assert property (p_push_contact) else $error("contact mode wrong");

   property p_push_begin;
      push_state == PUSH_IDLE && STEP_START_I && step_cfg[CFG_PUSH_BIT] && !STOP_CMD_I
         |=> push_state == PUSH_POSN;
   endproperty
   a_push_begin: assert property (p_push_begin) else $error("push not started");

   c_start_pulse: cover property (STEP_START_I && pif.fire ##1 pif.busy);
   c_pass_pulse:  cover property (pass_hit ##1 pif.busy);
   c_hold:        cover property (push_state == PUSH_FORCE ##1 push_state == PUSH_HOLD);
   c_nonstop:     cover property (push_state == PUSH_FORCE ##1 push_state == PUSH_NONSTOP);

endmodule // step_status_top

// ### logic/step_status_pkg.sv
// constants, register map and types shared by the step status block
package step_status_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS      = 25;
   localparam int unsigned TRIG_TIME_UNIT_NS  = 1_000_000;  // trigger time counts in ms
   localparam int unsigned MS_CYCLES_DEFAULT  = TRIG_TIME_UNIT_NS / CLK_PERIOD_NS;
   localparam int unsigned MS_CNT_W           = 16;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] STEP_CFG_OFS   = 8'h00;
   localparam logic [7:0] WAIT_TIME_OFS  = 8'h04;
   localparam logic [7:0] TRIG_POS_OFS   = 8'h08;
   localparam logic [7:0] TRIG_TIME_OFS  = 8'h0C;
   localparam logic [7:0] PUSH_RATIO_OFS = 8'h10;
   localparam logic [7:0] PUSH_SPEED_OFS = 8'h14;
   localparam logic [7:0] PUSH_POS_OFS   = 8'h18;
   localparam logic [7:0] PUSH_CNT_OFS   = 8'h1C;
   localparam logic [7:0] IRQ_STAT_OFS   = 8'h20;
   localparam logic [7:0] IRQ_MASK_OFS   = 8'h24;
   localparam logic [7:0] STATE_OFS      = 8'h28;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned CFG_SEL_LSB     = 0;   // step_output_select, 5 bits
   localparam int unsigned CFG_SEL_W       = 5;
   localparam int unsigned CFG_JUMP_BIT    = 8;
   localparam int unsigned CFG_PUSH_BIT    = 9;   // absolute_push_command
   localparam int unsigned CFG_NONSTOP_BIT = 10;
   localparam int unsigned IRQ_PULSE_BIT   = 0;
   localparam int unsigned IRQ_DONE_BIT    = 1;
   localparam int unsigned IRQ_CONTACT_BIT = 2;
   localparam int unsigned IRQ_W           = 3;
   localparam int unsigned RATIO_W         = 7;
   localparam int unsigned WAIT_W          = 16;

   // ----------------------------------------------------------------
   // reset values and select ranges
   // ----------------------------------------------------------------
   localparam logic [31:0] REG_RESET    = 32'h0000_0000;
   localparam logic [4:0]  SEL_END_BASE  = 5'h08;
   localparam logic [4:0]  SEL_PASS_BASE = 5'h10;

   typedef enum logic [2:0] {
      PUSH_IDLE    = 3'b000,
      PUSH_POSN    = 3'b001,
      PUSH_FORCE   = 3'b010,
      PUSH_HOLD    = 3'b011,
      PUSH_NONSTOP = 3'b100
   } push_state_type;

endpackage

// ### logic/pulse_if.sv
// carrier between the step sequencer and the status pulse generator
`timescale 1ns/1ps
interface pulse_if;
   logic                                    fire;   // start a new pulse
   logic [2:0]                              code;   // step_status_code
   logic [step_status_pkg::MS_CNT_W-1:0]    width;  // pulse width in ms
   logic [2:0]                              lines;  // step_status_line2..0
   logic                                    busy;   // pulse in progress

   modport gen (input fire, input code, input width, output lines, output busy);
   modport ctl (output fire, output code, output width, input lines, input busy);
endinterface

// ### logic/status_pulse_gen.sv
// timed pulse generator for the three step status lines
`timescale 1ns/1ps
module status_pulse_gen #(
   parameter int unsigned MS_CYCLES = step_status_pkg::MS_CYCLES_DEFAULT
) (
   input  wire logic clk_i,   // system clock
   input  wire logic srst_i,  // synchronous reset, active high
   pulse_if.gen      pif      // pulse request and lines
);
   import step_status_pkg::*;

   logic [2:0]          lines;
   logic                busy;
   logic [MS_CNT_W-1:0] tick_cnt;
   logic [MS_CNT_W-1:0] ms_left;
   logic [2:0]          next_lines;
   logic                next_busy;
   logic [MS_CNT_W-1:0] next_tick_cnt;
   logic [MS_CNT_W-1:0] next_ms_left;
   logic                tick_end;

   assign tick_end = (tick_cnt == MS_CNT_W'(MS_CYCLES - 1));

   always_comb begin
      next_lines    = lines;
      next_busy     = busy;
      next_tick_cnt = tick_cnt;
      next_ms_left  = ms_left;
      if (pif.fire) begin
         next_tick_cnt = '0;
         next_ms_left  = pif.width;
         // a zero width gives no pulse at all
         next_busy     = (pif.width != '0);
         next_lines    = (pif.width != '0) ? pif.code : 3'b000;
      end else if (busy) begin
         if (tick_end) begin
            next_tick_cnt = '0;
            next_ms_left  = ms_left - MS_CNT_W'(1);
            if (ms_left == MS_CNT_W'(1)) begin
               next_busy  = 1'b0;
               next_lines = 3'b000;
            end
         end else begin
            next_tick_cnt = tick_cnt + MS_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         lines    <= 3'b000;
         busy     <= 1'b0;
         tick_cnt <= '0;
         ms_left  <= '0;
      end else begin
         lines    <= next_lines;
         busy     <= next_busy;
         tick_cnt <= next_tick_cnt;
         ms_left  <= next_ms_left;
      end
   end

   assign pif.lines = lines;
   assign pif.busy  = busy;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   property p_code_out;
      pif.fire && pif.width != '0 |=> lines == $past(pif.code) && busy;
   endproperty
   a_code_out: assert property (p_code_out) else $error("pulse code not driven");

   property p_width_end;
      $fell(busy) && !$past(pif.fire) |-> $past(ms_left) == MS_CNT_W'(1) && $past(tick_end);
   endproperty
   a_width_end: assert property (p_width_end) else $error("pulse ended early");

   property p_idle_off;
      !busy |-> lines == 3'b000;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("lines on while idle");

endmodule // status_pulse_gen

// ### verification/host_model.sv
// host controller model: workpiece contact and stop command for push steps
`timescale 1ns/1ps
module host_model #(
   parameter int unsigned HOLD_CYC = 8  // stop follows HOLD_CYC + 1 cycles of contact
) (
   input  wire logic clk_i,          // system clock
   input  wire logic srst_i,         // synchronous reset, high
   input  wire logic push_active_i,  // force control applied
   input  wire logic contact_req_i,  // bench asks for a workpiece
   output logic      contact_o,      // workpiece detected
   output logic      stop_cmd_o      // stop command pulse
);
   logic [7:0] hold_cnt;
   logic [7:0] next_hold_cnt;
   logic       next_contact;
   logic       next_stop;
   always_comb begin
      next_contact  = contact_req_i && push_active_i;
      next_hold_cnt = (contact_o && push_active_i) ? hold_cnt + 8'h01 : 8'h00;
      next_stop     = (hold_cnt == 8'(HOLD_CYC));
   end
   always_ff @(posedge clk_i) begin
      contact_o  <= srst_i ? 1'b0 : next_contact;
      stop_cmd_o <= srst_i ? 1'b0 : next_stop;
      hold_cnt   <= srst_i ? 8'h00 : next_hold_cnt;
   end
endmodule // host_model

// ### verification/step_status_top_tb.sv
// self-checking bench for the step status lines and push sequencer
`timescale 1ns/1ps
module step_status_top_tb;
   import step_status_pkg::*;
   logic        sys_clk = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        step_start = 1'b0;
   logic        step_done = 1'b0;
   logic [31:0] pos = 32'h0000_0000;
   logic        contact_req = 1'b0;
   logic        contact, stop_cmd, push_active, motor_halt, irq;
   logic [31:0] rdata, push_speed, nonstop_cnt, rv;
   logic [2:0]  lines;
   logic [6:0]  force_ratio;
   int          fail_count = 0;
   int          checked = 0;
   int          cycles = 0;

   step_status_top #(.MS_CYCLES(4)) DUT (.SYS_CLK_I(sys_clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .STEP_START_I(step_start), .STEP_DONE_I(step_done), .POS_I(pos),
      .CONTACT_I(contact), .STOP_CMD_I(stop_cmd), .STATUS_LINES_O(lines), .PUSH_ACTIVE_O(push_active),
      .MOTOR_HALT_O(motor_halt), .FORCE_RATIO_O(force_ratio), .PUSH_SPEED_O(push_speed),
      .NONSTOP_CNT_O(nonstop_cnt), .IRQ_O(irq));
   host_model #(.HOLD_CYC(8)) host (.clk_i(sys_clk), .srst_i(srst), .push_active_i(push_active),
      .contact_req_i(contact_req), .contact_o(contact), .stop_cmd_o(stop_cmd));

   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   // a hung handshake must not stall the run
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // bus cycles and comparison
   // ----------------------------------------------------------------
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge sys_clk);
      wr    <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] a);
      @(posedge sys_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge sys_clk);
      rd   <= 1'b0;
      #1;
      rv = rdata;
   endtask
   task pulse(input int which);
      @(posedge sys_clk);
      step_start <= (which == 0);
      step_done  <= (which == 1);
      @(posedge sys_clk);
      step_start <= 1'b0;
      step_done  <= 1'b0;
      #1;
   endtask
   task chk32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_codes;
      logic [4:0] s;
      for (int i = 0; i < 24; i++) begin
         s = 5'(i);
         wr_reg(STEP_CFG_OFS, 32'(s));
         pulse(0);
         chk32(32'(lines), (s < SEL_END_BASE) ? 32'(s[2:0]) : 32'h0000_0000);
         tick(6);
         pulse(1);
         chk32(32'(lines), (s > SEL_END_BASE && s < SEL_PASS_BASE) ? 32'(s[2:0]) : 32'h0000_0000);
         tick(6);
      end
      $display("test codes done");
   endtask
   task t_width;
      wr_reg(TRIG_TIME_OFS, 32'h0000_0002);
      wr_reg(STEP_CFG_OFS, 32'h0000_0003);
      pulse(0);
      chk32(32'(lines), 32'h0000_0003);
      pulse(1);
      wr_reg(STEP_CFG_OFS, 32'h0000_0005);
      pulse(0);
      chk32(32'(lines), 32'h0000_0005);
      tick(7);
      chk32(32'(lines), 32'h0000_0005);
      tick(1);
      chk32(32'(lines), 32'h0000_0000);
      pulse(1);
      $display("test width done");
   endtask
   task t_pass;
      wr_reg(TRIG_POS_OFS, 32'h0000_0064);
      wr_reg(TRIG_TIME_OFS, 32'h0000_0001);
      wr_reg(STEP_CFG_OFS, 32'h0000_0013);
      @(posedge sys_clk) pos <= 32'h0000_1388;
      pulse(0);
      @(posedge sys_clk) pos <= 32'h0000_13EB;
      tick(2);
      chk32(32'(lines), 32'h0000_0000);
      @(posedge sys_clk) pos <= 32'h0000_13EC;
      tick(2);
      chk32(32'(lines), 32'h0000_0003);
      pulse(1);
      $display("test pass done");
   endtask
   task t_jump;
      wr_reg(WAIT_TIME_OFS, 32'h0000_0000);
      wr_reg(STEP_CFG_OFS, 32'h0000_010C);
      pulse(0);
      pulse(1);
      chk32(32'(lines), 32'h0000_0000);
      wr_reg(WAIT_TIME_OFS, 32'h0000_0005);
      pulse(0);
      pulse(1);
      chk32(32'(lines), 32'h0000_0004);
      tick(6);
      $display("test jump done");
   endtask
   task t_irq;
      rd_reg(IRQ_STAT_OFS);
      wr_reg(IRQ_MASK_OFS, 32'h0000_0001);
      wr_reg(STEP_CFG_OFS, 32'h0000_0001);
      pulse(0);
      tick(1);
      chk32(32'(irq), 32'h0000_0001);
      rd_reg(IRQ_STAT_OFS);
      chk32(rv, 32'h0000_0001);
      tick(1);
      chk32(32'(irq), 32'h0000_0000);
      wr_reg(IRQ_MASK_OFS, 32'h0000_0000);
      pulse(1);
      tick(1);
      chk32(32'(irq), 32'h0000_0000);
      wr_reg(IRQ_STAT_OFS, 32'h0000_0007);
      rd_reg(IRQ_STAT_OFS);
      chk32(rv, 32'h0000_0002);
      rd_reg(8'hFC);
      chk32(rv, 32'h0000_0000);
      $display("test irq done");
   endtask
   task t_push(input logic ns);
      wr_reg(PUSH_RATIO_OFS, 32'h0000_0032);
      wr_reg(PUSH_SPEED_OFS, 32'h0000_01F4);
      wr_reg(PUSH_POS_OFS, 32'h0000_00C8);
      wr_reg(PUSH_CNT_OFS, 32'h0000_00C8);
      wr_reg(STEP_CFG_OFS, 32'h0000_0200 | (32'(ns) << CFG_NONSTOP_BIT));
      chk32({force_ratio, push_speed[15:0], nonstop_cnt[8:0]}, {7'h32, 16'h01F4, 9'h0C8});
      @(posedge sys_clk) pos <= 32'h0000_0000;
      pulse(0);
      chk32(32'(push_active), 32'h0000_0000);
      @(posedge sys_clk) pos <= 32'h0000_00C8;
      tick(3);
      chk32(32'(push_active), 32'h0000_0001);
      @(posedge sys_clk) contact_req <= 1'b1;
      tick(4);
      chk32({push_active, motor_halt}, {1'b1, ~ns});
      rd_reg(STATE_OFS);
      chk32(rv, {24'h00_0000, 1'b1, (ns ? PUSH_NONSTOP : PUSH_HOLD), 4'h0});
      tick(20);
      chk32(32'(push_active), 32'h0000_0000);
      @(posedge sys_clk) contact_req <= 1'b0;
      pulse(1);
      $display("test push done");
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      rd_reg(TRIG_TIME_OFS);
      chk32(rv, REG_RESET);
      wr_reg(TRIG_POS_OFS, 32'h0000_03E8);
      wr_reg(TRIG_TIME_OFS, 32'h0000_0001);
      t_codes();
      t_width();
      t_pass();
      t_jump();
      t_irq();
      t_push(1'b0);
      t_push(1'b1);
      close_out();
   end
endmodule // step_status_top_tb
